// ===== bench/drive_partner.sv
// holding brake and shaft model on the far side of the sequencer
`timescale 1ns/10ps
module drive_partner #(
  parameter int LAG = 20,
  parameter int TOP = 3000
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic holding_brake_open,
  input wire logic ramp_up,
  input wire logic ramp_down,
  output logic [31:0] speed_actual,
  output logic brake_released
);
  int lag;
  // lag is kept inside the 5 ms open and close windows set by the bench
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lag <= 0;
      brake_released <= 1'b0;
    end else if (brake_released != holding_brake_open) begin
      lag <= lag + 1;
      if (lag == LAG) begin
        brake_released <= holding_brake_open;
        lag <= 0;
      end
    end else begin
      lag <= 0;
    end
  end
  // a closed brake holds the shaft still
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) speed_actual <= 32'h0;
    else if (!brake_released) speed_actual <= 32'h0;
    else if (ramp_down) speed_actual <= (speed_actual > 32'd100) ? speed_actual - 32'd100 : 32'h0;
    else if (ramp_up && speed_actual < TOP) speed_actual <= speed_actual + 32'd100;
  end
endmodule

// ===== bench/motor_brake_sequencer_tb.sv
// self-checking bench for the motor brake sequencer
`timescale 1ns/10ps
`include "motor_brake_defines.svh"
module motor_brake_sequencer_tb;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  logic ref_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, speed_actual, regen_limit_out, rd;
  logic pready, pslverr, pulse_enable, ramp_down, ramp_up, holding_brake_open;
  logic regen_overload_fault, vector_mode, brake_released;
  logic on_cmd = 1'b0, ramp_stop_cmd = 1'b0, coast_stop_cmd = 1'b0, torque_cutoff_request = 1'b0;
  logic [15:0] dcb_current_out;
  logic fault_valid = 1'b0;
  logic [15:0] fault_code = 16'h0000;
  int err_total = 0, comparisons = 0, n;
  row_t rows[14] = '{
    '{1'b0, `ADDR_DCB_SRC, 32'h0, 32'h0}, '{1'b0, `ADDR_DCB_CFG, 32'h0, 32'h0},
    '{1'b0, `ADDR_DCB_CUR, 32'h0, 32'h0}, '{1'b0, `ADDR_DCB_DUR, 32'h0, 32'h3e8},
    '{1'b0, `ADDR_DCB_SPD, 32'h0, 32'h33450}, '{1'b0, `ADDR_BOPEN, 32'h0, 32'h64},
    '{1'b0, 12'h050, 32'h0, 32'h0}, '{1'b1, 12'h050, 32'h5a, 32'h0},
    '{1'b1, `ADDR_BOPEN, 32'h5, 32'h5}, '{1'b1, `ADDR_BCLOSE, 32'h5, 32'h5},
    '{1'b1, `ADDR_MAG, 32'h2, 32'h2}, '{1'b1, `ADDR_DEEXC, 32'h2, 32'h2},
    '{1'b1, `ADDR_DCB_DUR, 32'h3, 32'h3}, '{1'b1, `ADDR_DCB_CUR, 32'h123, 32'h123}};

  always #5 ref_clk = ~ref_clk;

  motor_brake_sequencer #(.FAULT_DEPTH(8), .TICK_DIV(10)) u_dut (.ref_clk(ref_clk),
    .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .on_cmd(on_cmd),
    .ramp_stop_cmd(ramp_stop_cmd), .quick_stop_cmd(1'b0), .coast_stop_cmd(coast_stop_cmd),
    .torque_cutoff_request(torque_cutoff_request), .dcb_cmd_pin(1'b0),
    .fault_valid(fault_valid), .fault_code(fault_code), .speed_actual(speed_actual),
    .motor_current(16'h0000),
    .pulse_enable(pulse_enable), .ramp_down(ramp_down), .ramp_up(ramp_up),
    .dcb_current_out(dcb_current_out), .holding_brake_open(holding_brake_open),
    .regen_overload_fault(regen_overload_fault), .vector_mode(vector_mode),
    .regen_limit_out(regen_limit_out));

  drive_partner u_partner (.ref_clk(ref_clk), .nrst(nrst),
    .holding_brake_open(holding_brake_open), .ramp_up(ramp_up), .ramp_down(ramp_down),
    .speed_actual(speed_actual), .brake_released(brake_released));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    comparisons++;
    if (g < lo || g > hi) begin
      err_total++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic start_run();
    @(posedge ref_clk);
    on_cmd <= 1'b1;
    for (n = 0; n < 300 && ramp_up !== 1'b1; n++) @(negedge ref_clk);
    repeat (40) @(negedge ref_clk);
  endtask
  // coast stop, like torque cutoff, is an exit that works from every state
  task automatic stop_all();
    @(posedge ref_clk);
    coast_stop_cmd <= 1'b1;
    on_cmd <= 1'b0;
    ramp_stop_cmd <= 1'b0;
    repeat (3) @(posedge ref_clk);
    coast_stop_cmd <= 1'b0;
    repeat (30) @(posedge ref_clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #600000;
    err_total++;
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk("register", rows[i].e, rd);
      chk("slave error", 32'h0, {31'h0, pslverr});
    end
    @(posedge ref_clk);
    on_cmd <= 1'b1;
    for (n = 0; n < 100 && holding_brake_open !== 1'b1; n++) @(negedge ref_clk);
    chk_rng("magnetize wait", 10, 35, n);
    for (n = 0; n < 200 && ramp_up !== 1'b1; n++) @(negedge ref_clk);
    chk_rng("brake open wait", 40, 62, n);
    chk("brake released", 32'h1, {31'h0, brake_released});
    repeat (40) @(negedge ref_clk);
    @(posedge ref_clk);
    ramp_stop_cmd <= 1'b1;
    for (n = 0; n < 300 && holding_brake_open !== 1'b0; n++) @(negedge ref_clk);
    chk("slow at close", 32'h1, {31'h0, speed_actual < 32'd20});
    chk("energized at close", 32'h1, {31'h0, pulse_enable});
    for (n = 0; n < 200 && pulse_enable !== 1'b0; n++) @(negedge ref_clk);
    chk_rng("brake close wait", 40, 62, n);
    chk("brake engaged", 32'h0, {31'h0, brake_released});
    chk("overload trip", 32'h0, {31'h0, regen_overload_fault});
    stop_all();
    for (int k = 0; k < 2; k++) begin
      start_run();
      @(posedge ref_clk);
      coast_stop_cmd <= (k == 0);
      torque_cutoff_request <= (k == 1);
      repeat (3) @(negedge ref_clk);
      chk("brake at stop", 32'h0, {31'h0, holding_brake_open});
      chk("pulses at stop", 32'h0, {31'h0, pulse_enable});
      @(posedge ref_clk);
      torque_cutoff_request <= 1'b0;
      stop_all();
    end
    start_run();
    apb(1'b1, `ADDR_DCB_CFG, 32'h4);
    apb(1'b1, `ADDR_DCB_SRC, 32'h1);
    for (n = 0; n < 200 && pulse_enable !== 1'b0; n++) @(negedge ref_clk);
    chk_rng("source level", 0, 199, n);
    for (n = 0; n < 60 && dcb_current_out !== 16'h0123; n++) @(negedge ref_clk);
    chk_rng("deexcite wait", 10, 32, n);
    for (n = 0; n < 80 && dcb_current_out === 16'h0123; n++) @(negedge ref_clk);
    chk_rng("inject time", 20, 42, n);
    apb(1'b1, `ADDR_DCB_SRC, 32'h0);
    stop_all();
    start_run();
    apb(1'b1, `ADDR_DCB_SRC, 32'h1);
    for (n = 0; n < 200 && dcb_current_out !== 16'h0123; n++) @(negedge ref_clk);
    apb(1'b1, `ADDR_DCB_SRC, 32'h0);
    for (n = 0; n < 12 && (ramp_up !== 1'b1 || dcb_current_out !== 16'h0); n++)
      @(negedge ref_clk);
    chk_rng("abort", 0, 9, n);
    stop_all();
    apb(1'b1, `ADDR_FAULT_IDX, 32'h3);
    apb(1'b1, `ADDR_FAULT_NUM, 32'h42);
    apb(1'b1, `ADDR_FAULT_RSP, 32'h6);
    apb(1'b1, `ADDR_DCB_SPD, 32'h3e8);
    start_run();
    @(posedge ref_clk);
    fault_valid <= 1'b1;
    fault_code <= 16'h0042;
    repeat (20) @(negedge ref_clk);
    chk("unpermitted fault", 32'h0, {31'h0, ramp_down});
    apb(1'b1, `ADDR_FAULT_OK, 32'h8);
    for (n = 0; n < 20 && ramp_down !== 1'b1; n++) @(negedge ref_clk);
    chk_rng("fault decel", 0, 9, n);
    for (n = 0; n < 100 && pulse_enable !== 1'b0; n++) @(negedge ref_clk);
    chk("fault brake speed", 32'h1, {31'h0, speed_actual < 32'd1000 && speed_actual != 0});
    @(posedge ref_clk);
    fault_valid <= 1'b0;
    stop_all();
    apb(1'b1, `ADDR_DCB_CFG, 32'he);
    start_run();
    @(posedge ref_clk);
    ramp_stop_cmd <= 1'b1;
    for (n = 0; n < 100 && pulse_enable !== 1'b0; n++) @(negedge ref_clk);
    chk("below start", 32'h1, {31'h0, speed_actual < 32'd1000 && speed_actual != 0});
    stop_all();
    apb(1'b1, `ADDR_DCB_CFG, 32'h5);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk("status stop bit", 32'h1, {31'h0, rd[13]});
    apb(1'b1, `ADDR_MODE, 32'h14);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk("vector mode", 32'h1, {31'h0, vector_mode});
    chk("status lock bit", 32'h1, {31'h0, rd[12]});
    apb(1'b1, `ADDR_RATING, 32'h64);
    apb(1'b1, `ADDR_REGEN, 32'hffffff38);
    repeat (3) @(negedge ref_clk);
    chk("regen clip", 32'hffffff9c, regen_limit_out);
    apb(1'b1, `ADDR_REGEN, 32'h5);
    repeat (3) @(negedge ref_clk);
    chk("regen positive", 32'h0, regen_limit_out);
    apb(1'b1, `ADDR_MODE, 32'h13);
    repeat (3) @(negedge ref_clk);
    chk("vf mode", 32'h0, {31'h0, vector_mode});
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    apb(1'b0, `ADDR_DCB_DUR, 32'h0);
    chk("duration after reset", 32'h3e8, rd);
    print_verdict();
  end
endmodule

// ===== hw/motor_brake_defines.svh
// shared constants for the motor brake sequencer
`ifndef MOTOR_BRAKE_DEFINES_SVH
`define MOTOR_BRAKE_DEFINES_SVH
`define ADDR_CTRL 12'h000
`define ADDR_DCB_SRC 12'h004
`define ADDR_DCB_CFG 12'h008
`define ADDR_DCB_CUR 12'h00c
`define ADDR_DCB_DUR 12'h010
`define ADDR_DCB_SPD 12'h014
`define ADDR_DEEXC 12'h018
`define ADDR_MAG 12'h01c
`define ADDR_BOPEN 12'h020
`define ADDR_BCLOSE 12'h024
`define ADDR_MODE 12'h028
`define ADDR_OVL 12'h02c
`define ADDR_REGEN 12'h030
`define ADDR_RATING 12'h034
`define ADDR_STATUS 12'h038
`define ADDR_FAULT_IDX 12'h03c
`define ADDR_FAULT_NUM 12'h040
`define ADDR_FAULT_RSP 12'h044
`define ADDR_FAULT_OK 12'h048
`define ADDR_SEQ 12'h04c
`define CFG_NONE 8'h00
`define CFG_GENERAL 8'h04
`define CFG_OFF13 8'h05
`define CFG_BELOW 8'h0e
`define RSP_DCB 8'h06
`define MODE_VECTOR 8'h14
`define DCB_CUR_RST 16'h0000
`define DCB_DUR_RST 16'h03e8
`define DCB_SPD_RST 32'h00033450
`define CLOSE_SPEED 32'h00000014
`define OVL_TIME_MS 16'h2710
`define BRAKE_TIME_RST 16'h0064
`define OVL_LIMIT_RST 16'hffff
`define RATING_RST 32'h7fffffff
`define ST_ACTIVE 8
`define ST_READY 10
`define ST_SELECTED 11
`define ST_LOCKED 12
`define ST_OFF13 13
`define CLK_HZ 100000000
`define TICK_HZ 1000
`endif

// ===== hw/motor_brake_pkg.sv
// types for the motor brake sequencer
package motor_brake_pkg;
  typedef enum logic [3:0] {
    S_OFF, S_MAGNETIZE, S_OPENING, S_RUN, S_DECEL, S_CLOSING,
    S_DEEXCITE, S_DCB
  } seq_state_t;
endpackage

// ===== hw/motor_brake_sequencer.sv
// dc braking and holding brake sequencer with apb registers
`timescale 1ns/10ps
`include "motor_brake_defines.svh"
module motor_brake_sequencer #(
  parameter int FAULT_DEPTH = 8,
  parameter int TICK_DIV = `CLK_HZ / `TICK_HZ
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic on_cmd,
  input wire logic ramp_stop_cmd,
  input wire logic quick_stop_cmd,
  input wire logic coast_stop_cmd,
  input wire logic torque_cutoff_request,
  input wire logic dcb_cmd_pin,
  input wire logic fault_valid,
  input wire logic [15:0] fault_code,
  input wire logic [31:0] speed_actual,
  input wire logic [15:0] motor_current,
  output logic pulse_enable,
  output logic ramp_down,
  output logic ramp_up,
  output logic [15:0] dcb_current_out,
  output logic holding_brake_open,
  output logic regen_overload_fault,
  output logic vector_mode,
  output logic [31:0] regen_limit_out
);
  logic [1:0] dcb_activate_src;
  logic [7:0] dcb_config, control_mode_select;
  logic [15:0] dcb_current, dcb_duration, deexcite_time, magnetize_time;
  logic [15:0] brake_open_time, brake_close_time, overload_factor;
  logic [31:0] dcb_start_speed, regen_power_limit, power_unit_rating;
  logic [15:0] fault_number_table [FAULT_DEPTH];
  logic [7:0] fault_response_table [FAULT_DEPTH];
  logic [FAULT_DEPTH-1:0] dc_brake_response_option;
  logic [$clog2(FAULT_DEPTH)-1:0] fault_idx;
  logic [31:0] tick_cnt;
  logic tick, armed, fault_dcb, fault_dcb_hit;
  logic [2:0] pin_sync;
  logic dcb_pin_level;
  motor_brake_pkg::seq_state_t state;
  logic t_done, ovl_done, over_limit;
  logic [15:0] t_limit;
  logic state_chg;
  logic wr, rd;
  logic dcb_src_level, dcb_selected, dcb_locked, dcb_ready;

  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;

  // three-stage sync; change counts when stages two and three agree
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_sync <= 3'h0;
      dcb_pin_level <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[1:0], dcb_cmd_pin};
      if (pin_sync[2] == pin_sync[1]) begin
        dcb_pin_level <= pin_sync[2];
      end
    end
  end

  // src 0 const 0, 1 const 1, 2 pin level
  always_comb begin
    unique case (dcb_activate_src)
      2'h1: dcb_src_level = 1'b1;
      2'h2: dcb_src_level = dcb_pin_level;
      default: dcb_src_level = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dcb_activate_src <= 2'h0;
      dcb_config <= `CFG_NONE;
      dcb_current <= `DCB_CUR_RST;
      dcb_duration <= `DCB_DUR_RST;
      dcb_start_speed <= `DCB_SPD_RST;
      deexcite_time <= 16'h0000;
      magnetize_time <= 16'h0000;
      brake_open_time <= `BRAKE_TIME_RST;
      brake_close_time <= `BRAKE_TIME_RST;
      control_mode_select <= 8'h00;
      overload_factor <= `OVL_LIMIT_RST;
      regen_power_limit <= 32'h00000000;
      power_unit_rating <= `RATING_RST;
      fault_idx <= '0;
      dc_brake_response_option <= '0;
    end else if (wr) begin
      unique case (paddr)
        `ADDR_DCB_SRC: dcb_activate_src <= pwdata[1:0];
        `ADDR_DCB_CFG: dcb_config <= pwdata[7:0];
        `ADDR_DCB_CUR: dcb_current <= pwdata[15:0];
        `ADDR_DCB_DUR: dcb_duration <= pwdata[15:0];
        `ADDR_DCB_SPD: dcb_start_speed <= pwdata;
        `ADDR_DEEXC: deexcite_time <= pwdata[15:0];
        `ADDR_MAG: magnetize_time <= pwdata[15:0];
        `ADDR_BOPEN: brake_open_time <= pwdata[15:0];
        `ADDR_BCLOSE: brake_close_time <= pwdata[15:0];
        `ADDR_MODE: control_mode_select <= pwdata[7:0];
        `ADDR_OVL: overload_factor <= pwdata[15:0];
        `ADDR_REGEN: regen_power_limit <= pwdata;
        `ADDR_RATING: power_unit_rating <= pwdata;
        `ADDR_FAULT_IDX: fault_idx <= pwdata[$clog2(FAULT_DEPTH)-1:0];
        `ADDR_FAULT_OK: dc_brake_response_option <= pwdata[FAULT_DEPTH-1:0];
        default: ;
      endcase
    end
  end

  // tables indexed through fault_idx
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < FAULT_DEPTH; i++) begin
        fault_number_table[i] <= 16'h0000;
        fault_response_table[i] <= 8'h00;
      end
    end else if (wr && paddr == `ADDR_FAULT_NUM) begin
      fault_number_table[fault_idx] <= pwdata[15:0];
    end else if (wr && paddr == `ADDR_FAULT_RSP) begin
      fault_response_table[fault_idx] <= pwdata[7:0];
    end
  end

  // match fault code; response honoured only where the option is allowed
  always_comb begin
    fault_dcb_hit = 1'b0;
    for (int i = 0; i < FAULT_DEPTH; i++) begin
      if (fault_valid && fault_code != 16'h0000 && fault_number_table[i] == fault_code &&
          fault_response_table[i] == `RSP_DCB && dc_brake_response_option[i]) begin
        fault_dcb_hit = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fault_dcb <= 1'b0;
    end else if (fault_dcb_hit) begin
      fault_dcb <= 1'b1;
    end else if (state == motor_brake_pkg::S_OFF && !on_cmd) begin
      fault_dcb <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt <= 32'h0;
    end else if (tick) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end
  assign tick = (tick_cnt == 32'(TICK_DIV - 1));

  assign dcb_selected = dcb_config != `CFG_NONE;
  assign dcb_locked = control_mode_select >= `MODE_VECTOR;
  assign dcb_ready = dcb_selected && !dcb_locked && dcb_current != `DCB_CUR_RST;
  wire stop_req = ramp_stop_cmd || quick_stop_cmd;
  wire hard_stop = coast_stop_cmd || torque_cutoff_request;
  wire below = speed_actual < dcb_start_speed;
  wire brake_req = (dcb_config == `CFG_GENERAL && dcb_src_level) ||
                   (dcb_config == `CFG_OFF13 && stop_req) || fault_dcb ||
                   (dcb_config == `CFG_BELOW && armed && below);

  // arm when speed exceeds the threshold
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      armed <= 1'b0;
    end else if (state == motor_brake_pkg::S_DCB || state == motor_brake_pkg::S_OFF) begin
      armed <= 1'b0;
    end else if (speed_actual > dcb_start_speed) begin
      armed <= 1'b1;
    end
  end

  always_comb begin
    unique case (state)
      motor_brake_pkg::S_MAGNETIZE: t_limit = magnetize_time;
      motor_brake_pkg::S_OPENING: t_limit = brake_open_time;
      motor_brake_pkg::S_CLOSING: t_limit = brake_close_time;
      motor_brake_pkg::S_DEEXCITE: t_limit = deexcite_time;
      motor_brake_pkg::S_DCB: t_limit = dcb_duration;
      default: t_limit = 16'h0000;
    endcase
  end

  ms_timer #(.W(16)) wait_timer (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .tick(tick),
    .clear(state_chg),
    .limit(t_limit),
    .done(t_done)
  );

  motor_brake_pkg::seq_state_t next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      motor_brake_pkg::S_OFF: if (on_cmd && !hard_stop && !stop_req) begin
        next_state = motor_brake_pkg::S_MAGNETIZE;
      end
      motor_brake_pkg::S_MAGNETIZE: if (t_done) begin
        next_state = motor_brake_pkg::S_OPENING;
      end
      motor_brake_pkg::S_OPENING: if (t_done) begin
        next_state = motor_brake_pkg::S_RUN;
      end
      // a direct command, or any brake request below the start speed, skips the ramp when dcb_ready is set; others decelerate first
      motor_brake_pkg::S_RUN: if (brake_req && dcb_ready && (below ||
          (dcb_config == `CFG_GENERAL && dcb_src_level))) begin
        next_state = motor_brake_pkg::S_DEEXCITE;
      end else if (stop_req || brake_req) begin
        next_state = motor_brake_pkg::S_DECEL;
      end
      motor_brake_pkg::S_DECEL: if (brake_req && dcb_ready && below) begin
        next_state = motor_brake_pkg::S_DEEXCITE;
      end else if (!stop_req && !brake_req) begin
        next_state = motor_brake_pkg::S_RUN;
      end else if (speed_actual < `CLOSE_SPEED) begin
        next_state = motor_brake_pkg::S_CLOSING;
      end
      motor_brake_pkg::S_CLOSING: if (t_done) begin
        next_state = motor_brake_pkg::S_OFF;
      end
      motor_brake_pkg::S_DEEXCITE: if (!brake_req) begin
        next_state = motor_brake_pkg::S_RUN;
      end else if (t_done) begin
        next_state = motor_brake_pkg::S_DCB;
      end
      motor_brake_pkg::S_DCB: if (!brake_req) begin
        next_state = motor_brake_pkg::S_RUN;
      end else if (t_done) begin
        next_state = stop_req ? motor_brake_pkg::S_CLOSING : motor_brake_pkg::S_OFF;
      end
      default: next_state = motor_brake_pkg::S_OFF;
    endcase
    // coast stop, cutoff and overload trip bypass every wait
    if (hard_stop || regen_overload_fault) begin
      next_state = motor_brake_pkg::S_OFF;
    end
  end
  assign state_chg = next_state != state;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= motor_brake_pkg::S_OFF;
    end else begin
      state <= next_state;
    end
  end

  // v/f overload: current over the limit for 10 s trips
  assign over_limit = !vector_mode && motor_current > overload_factor;
  ms_timer #(.W(16)) ovl_timer (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .tick(tick),
    .clear(!over_limit),
    .limit(`OVL_TIME_MS),
    .done(ovl_done)
  );

  // trip latches until the motor is commanded off
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      regen_overload_fault <= 1'b0;
    end else if (over_limit && ovl_done) begin
      regen_overload_fault <= 1'b1;
    end else if (!on_cmd) begin
      regen_overload_fault <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      vector_mode <= 1'b0;
      regen_limit_out <= 32'h0;
    end else begin
      vector_mode <= control_mode_select >= `MODE_VECTOR;
      // limit is negative; magnitude clipped to the unit rating
      if ($signed(regen_power_limit) > 0) begin
        regen_limit_out <= 32'h0;
      end else if (32'(-$signed(regen_power_limit)) > power_unit_rating) begin
        regen_limit_out <= 32'(-$signed(power_unit_rating));
      end else begin
        regen_limit_out <= regen_power_limit;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pulse_enable <= 1'b0;
      ramp_down <= 1'b0;
      ramp_up <= 1'b0;
      holding_brake_open <= 1'b0;
      dcb_current_out <= 16'h0000;
    end else begin
      pulse_enable <= next_state != motor_brake_pkg::S_OFF &&
                      next_state != motor_brake_pkg::S_DEEXCITE;
      ramp_down <= next_state == motor_brake_pkg::S_DECEL;
      ramp_up <= next_state == motor_brake_pkg::S_RUN;
      // shaft still turns during dc braking; closing the brake there would wear it
      holding_brake_open <= next_state == motor_brake_pkg::S_OPENING ||
                            next_state == motor_brake_pkg::S_RUN ||
                            next_state == motor_brake_pkg::S_DEEXCITE ||
                            next_state == motor_brake_pkg::S_DCB ||
                            next_state == motor_brake_pkg::S_DECEL;
      dcb_current_out <= next_state == motor_brake_pkg::S_DCB ? dcb_current : 16'h0000;
    end
  end

  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0;
    status_word[`ST_ACTIVE] = state == motor_brake_pkg::S_DCB;
    status_word[`ST_READY] = dcb_ready;
    status_word[`ST_SELECTED] = dcb_selected;
    status_word[`ST_LOCKED] = dcb_locked;
    status_word[`ST_OFF13] = dcb_config == `CFG_OFF13;
  end

  // read data captured in setup phase, valid in access phase
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (rd) begin
      pslverr <= 1'b0;
      unique case (paddr)
        `ADDR_DCB_SRC: prdata <= {30'h0, dcb_activate_src};
        `ADDR_DCB_CFG: prdata <= {24'h0, dcb_config};
        `ADDR_DCB_CUR: prdata <= {16'h0, dcb_current};
        `ADDR_DCB_DUR: prdata <= {16'h0, dcb_duration};
        `ADDR_DCB_SPD: prdata <= dcb_start_speed;
        `ADDR_DEEXC: prdata <= {16'h0, deexcite_time};
        `ADDR_MAG: prdata <= {16'h0, magnetize_time};
        `ADDR_BOPEN: prdata <= {16'h0, brake_open_time};
        `ADDR_BCLOSE: prdata <= {16'h0, brake_close_time};
        `ADDR_MODE: prdata <= {24'h0, control_mode_select};
        `ADDR_OVL: prdata <= {16'h0, overload_factor};
        `ADDR_REGEN: prdata <= regen_power_limit;
        `ADDR_RATING: prdata <= power_unit_rating;
        `ADDR_STATUS: prdata <= status_word;
        `ADDR_FAULT_NUM: prdata <= {16'h0, fault_number_table[fault_idx]};
        `ADDR_FAULT_RSP: prdata <= {24'h0, fault_response_table[fault_idx]};
        `ADDR_SEQ: prdata <= {28'h0, state};
        default: prdata <= 32'h0;
      endcase
    end else if (!psel) begin
      prdata <= 32'h0;
    end
  end

  sequence hard_stop_s;
    hard_stop ##1 1'b1;
  endsequence
  AST_HARD_CLOSE: assert property (@(posedge ref_clk) disable iff (!nrst)
    hard_stop_s |-> !holding_brake_open) else $error("brake not closed on hard stop");
  AST_OPEN_AFTER_MAG: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(holding_brake_open) |-> $past(state) == motor_brake_pkg::S_MAGNETIZE)
    else $error("brake opened without magnetizing");
  AST_DCB_NO_PULSE: assert property (@(posedge ref_clk) disable iff (!nrst)
    state == motor_brake_pkg::S_DEEXCITE |=> !pulse_enable || state != motor_brake_pkg::S_DEEXCITE)
    else $error("pulses on during de-excitation");
  AST_DCB_CUR: assert property (@(posedge ref_clk) disable iff (!nrst)
    state == motor_brake_pkg::S_DCB |-> dcb_current_out == dcb_current)
    else $error("wrong braking current");
  // active bit may only rise straight out of de-excitation
  AST_STATUS_ACTIVE: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(status_word[`ST_ACTIVE]) |-> $past(state) == motor_brake_pkg::S_DEEXCITE)
    else $error("status active without de-excitation");
  AST_CLOSE_SLOW: assert property (@(posedge ref_clk) disable iff (!nrst)
    state == motor_brake_pkg::S_CLOSING |-> !holding_brake_open && pulse_enable)
    else $error("closing without energized motor");
  AST_VECTOR: assert property (@(posedge ref_clk) disable iff (!nrst)
    ##1 vector_mode == ($past(control_mode_select) >= `MODE_VECTOR))
    else $error("control mode decode wrong");
  AST_REGEN_CLIP: assert property (@(posedge ref_clk) disable iff (!nrst)
    ##1 $signed(regen_limit_out) <= 0) else $error("regen limit positive");
  AST_ABORT: assert property (@(posedge ref_clk) disable iff (!nrst)
    state == motor_brake_pkg::S_DCB && !brake_req && !hard_stop && !regen_overload_fault
    |=> state == motor_brake_pkg::S_RUN) else $error("abort did not re-accelerate");
endmodule

// ===== hw/ms_timer.sv
// millisecond wait counter, restarts while clear is high
`timescale 1ns/10ps
module ms_timer #(
  parameter int W = 16
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic clear,
  input wire logic [W-1:0] limit,
  output logic done
);
  logic [W-1:0] cnt;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= '0;
    end else if (clear) begin
      cnt <= '0;
    end else if (tick && cnt != limit) begin
      cnt <= cnt + 1'b1;
    end
  end
  assign done = (cnt == limit);
endmodule
